// ===== rtl/sbp_regs.vh
`ifndef SBP_REGS_VH
`define SBP_REGS_VH
// Address width of the fetch path.
`define SBP_ADDR_W 32
// Branch type encodings from decode.
`define SBP_TYPE_W 2
`define SBP_TYPE_NONE 2'h0
`define SBP_TYPE_UNCOND 2'h1
`define SBP_TYPE_INDIRECT 2'h2
`define SBP_TYPE_COND 2'h3
// Prediction source encodings.
`define SBP_SRC_W 2
`define SBP_SRC_NONE 2'h0
`define SBP_SRC_STATIC 2'h1
`define SBP_SRC_DYNAMIC 2'h2
`define SBP_SRC_DEFAULT 2'h3
// Polling-loop guard window in cycles after a spin-wait hint.
`define SBP_SPIN_HOLD 8'h10
// Width and end points of the polling-window counter.
`define SBP_SPIN_W 8
`define SBP_SPIN_ZERO 8'h00
`define SBP_SPIN_ONE 8'h01
`endif

// ===== rtl/sbp_dir.v
`timescale 1ns/1ps
// Combinational static direction heuristic for one branch.
module sbp_dir (
  // Branch description
  input wire [1:0] type_in,
  input wire backward_in,
  // Result
  output reg taken_out
);
`include "sbp_regs.vh"
  // Direction from branch type and displacement sign.
  always @* begin
    taken_out = 1'b0;
    case (type_in)
      `SBP_TYPE_UNCOND: taken_out = 1'b1;
      `SBP_TYPE_INDIRECT: taken_out = 1'b0;
      `SBP_TYPE_COND: taken_out = backward_in;
      default: taken_out = 1'b0;
    endcase
  end
endmodule

// ===== rtl/sbp_static_branch_predictor.v
`timescale 1ns/1ps
`include "sbp_regs.vh"
module sbp_static_branch_predictor #(
  parameter STATIC_EN = 1
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // Decoded branch from fetch/decode
  input wire valid_in,
  input wire [`SBP_TYPE_W-1:0] type_in,
  input wire [`SBP_ADDR_W-1:0] pc_in,
  input wire [`SBP_ADDR_W-1:0] target_in,
  input wire [`SBP_ADDR_W-1:0] next_pc_in,
  input wire spin_hint_in,
  // Branch target buffer lookup
  input wire btb_hit_in,
  input wire btb_taken_in,
  input wire [`SBP_ADDR_W-1:0] btb_target_in,
  // Branch resolution from execute
  input wire resolve_valid_in,
  input wire [`SBP_TYPE_W-1:0] resolve_type_in,
  input wire resolve_taken_in,
  input wire resolve_hit_in,
  // Prediction to fetch
  output reg pred_valid_out,
  output reg pred_taken_out,
  output reg [`SBP_ADDR_W-1:0] pred_pc_out,
  output reg [1:0] pred_src_out,
  // Buffer allocation request
  output wire alloc_out,
  // Spin-wait hint handling
  output reg nop_issue_out,
  output reg poll_loop_out
);
  // Decode helpers for the branch in flight.
  wire is_branch;
  wire backward;
  wire heur_taken;
  wire hint_seen;
  wire pred_fire;
  // Direction and source chosen for this cycle.
  reg dyn_taken;
  reg static_taken;
  reg taken_d;
  reg [`SBP_SRC_W-1:0] src_d;
  reg [`SBP_ADDR_W-1:0] pc_d;
  // Next values of the registered prediction outputs.
  reg pred_valid_d;
  reg pred_taken_d;
  reg [`SBP_ADDR_W-1:0] pred_pc_d;
  reg [`SBP_SRC_W-1:0] pred_src_d;
  // Polling-window counter and the next values of the hint outputs.
  reg [`SBP_SPIN_W-1:0] spin_cnt_q;
  reg [`SBP_SPIN_W-1:0] spin_cnt_d;
  reg nop_issue_d;
  reg poll_loop_d;
  // Allocation qualifiers from the resolution port.
  wire resolve_is_branch;
  wire resolve_is_new;

  // A slot carries a branch when decode marks it valid and gives it a type.
  // A slot typed as no branch never raises a prediction.
  assign is_branch = (type_in != `SBP_TYPE_NONE);
  assign pred_fire = valid_in && is_branch;

  // Backward means the target lies strictly below the branch.
  // An equal address counts as forward, so a conditional branch to it falls through.
  assign backward = (target_in < pc_in);

  // A spin-wait hint only counts in a valid decode slot.
  assign hint_seen = valid_in && spin_hint_in;

  // Static direction from branch type and displacement sign.
  sbp_dir sbp_dir_inst (
    .type_in(type_in),
    .backward_in(backward),
    .taken_out(heur_taken)
  );

  // Dynamic direction, used whenever the buffer holds the branch.
  // A miss leaves it low so that it can never leak into the static path.
  always @* begin
    dyn_taken = 1'b0;
    if (btb_hit_in) begin
      dyn_taken = btb_taken_in;
    end
  end

  // Static direction, forced to fall-through in a build without the heuristic.
  // Such a build trades first-pass loop accuracy for less logic.
  always @* begin
    static_taken = 1'b0;
    if (STATIC_EN != 0) begin
      static_taken = heur_taken;
    end else begin
      static_taken = 1'b0;
    end
  end

  // Select the direction and name its source; the buffer always wins.
  // The static heuristic is only consulted on a buffer miss.
  always @* begin
    taken_d = 1'b0;
    src_d = `SBP_SRC_NONE;
    if (btb_hit_in) begin
      taken_d = dyn_taken;
      src_d = `SBP_SRC_DYNAMIC;
    end else if (STATIC_EN != 0) begin
      taken_d = static_taken;
      src_d = `SBP_SRC_STATIC;
    end else begin
      taken_d = static_taken;
      src_d = `SBP_SRC_DEFAULT;
    end
  end

  // Next fetch address: buffer target, decoded target or fall-through.
  // A not-taken buffer hit still fetches sequentially.
  always @* begin
    pc_d = next_pc_in;
    if (btb_hit_in && btb_taken_in) begin
      pc_d = btb_target_in;
    end else if (!btb_hit_in && taken_d) begin
      pc_d = target_in;
    end else begin
      pc_d = next_pc_in;
    end
  end

  // Gate the prediction so that a slot without a branch shows nothing.
  // The address is passed through; fetch ignores it without the valid flag.
  always @* begin
    pred_valid_d = pred_fire;
    pred_taken_d = 1'b0;
    pred_pc_d = pc_d;
    pred_src_d = `SBP_SRC_NONE;
    if (pred_fire) begin
      pred_taken_d = taken_d;
      pred_src_d = src_d;
    end
  end

  // Register the prediction toward fetch; each value stands for one cycle.
  // Back-to-back branches simply overwrite the previous prediction.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pred_valid_out <= 1'b0;
      pred_taken_out <= 1'b0;
      pred_pc_out <= {`SBP_ADDR_W{1'b0}};
      pred_src_out <= `SBP_SRC_NONE;
    end else begin
      pred_valid_out <= pred_valid_d;
      pred_taken_out <= pred_taken_d;
      pred_pc_out <= pred_pc_d;
      pred_src_out <= pred_src_d;
    end
  end

  // Resolution of a real branch that the buffer did not hold yet.
  // A branch already in the buffer never asks for a second entry.
  assign resolve_is_branch = (resolve_type_in != `SBP_TYPE_NONE);
  assign resolve_is_new = resolve_valid_in && !resolve_hit_in && resolve_is_branch;

  // Only a branch seen taken earns an entry, so never-taken conditionals cost none.
  // The request is combinational so the buffer can write in the resolving cycle.
  assign alloc_out = resolve_is_new && resolve_taken_in;

  // The hint changes no architectural state; it reports that it retired and opens the polling window.
  // Apart from the polling-window counter and the two hint output registers, no register, flag or memory path is touched by it in this block.
  always @* begin
    nop_issue_d = hint_seen;
  end

  // Reload the window on each hint and count it down otherwise.
  // The window stays open through the reload value of cycles after the last hint.
  always @* begin
    spin_cnt_d = spin_cnt_q;
    poll_loop_d = 1'b0;
    if (hint_seen) begin
      spin_cnt_d = `SBP_SPIN_HOLD;
      poll_loop_d = 1'b1;
    end else if (spin_cnt_q != `SBP_SPIN_ZERO) begin
      spin_cnt_d = spin_cnt_q - `SBP_SPIN_ONE;
      poll_loop_d = (spin_cnt_q != `SBP_SPIN_ONE);
    end else begin
      spin_cnt_d = `SBP_SPIN_ZERO;
      poll_loop_d = 1'b0;
    end
  end

  // Hint outputs; the window lets the loop exit without an ordering flush.
  // Reset closes the window so a stale loop is never assumed.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      nop_issue_out <= 1'b0;
      spin_cnt_q <= `SBP_SPIN_ZERO;
      poll_loop_out <= 1'b0;
    end else begin
      nop_issue_out <= nop_issue_d;
      spin_cnt_q <= spin_cnt_d;
      poll_loop_out <= poll_loop_d;
    end
  end
endmodule

// ===== testbench/sbp_fetch_model.sv
`timescale 1ns/1ps
// Decode stage: {valid,hint,hit,buffer dir,type,pc,target}, changed just after an edge.
module sbp_fetch_model (
  input wire core_clk_in,
  output logic [69:0] f_out = '0
);
  task automatic put(input logic [69:0] f);
    @(posedge core_clk_in) #1 f_out = f;
  endtask
endmodule

// ===== testbench/sbp_asserts.sv
`timescale 1ns/1ps
// Port checker.
module sbp_asserts (input wire core_clk_in, rst_in, valid_in, spin_hint_in, btb_hit_in,
  btb_taken_in, resolve_valid_in, resolve_taken_in, resolve_hit_in, alloc_out, nop_issue_out,
  poll_loop_out,
  pred_taken_out, input wire [1:0] type_in, pred_src_out, input wire [31:0] pc_in, target_in);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Buffer misses by kind.
  wire m = valid_in&&!btb_hit_in, u = m&&type_in==2'h1, i = m&&type_in==2'h2;
  wire f = m&&type_in==2'h3&&target_in>=pc_in, k = m&&type_in==2'h3&&target_in<pc_in;
  a_jump_taken: assert property (u |=> pred_taken_out) else $error("jump");
  a_indir_fall: assert property (i |=> !pred_taken_out) else $error("indir");
  a_fwd_fall: assert property (f |=> !pred_taken_out) else $error("fwd");
  a_back_taken: assert property (k |=> pred_taken_out) else $error("back");
  a_static_src: assert property (u|i|f|k |=> pred_src_out==2'h1)
    else $error("src");
  a_dyn_wins: assert property (valid_in&&btb_hit_in&&type_in!=2'h0 |=>
    pred_src_out==2'h2&&pred_taken_out==$past(btb_taken_in)) else $error("hit");
  a_no_alloc: assert property (resolve_valid_in&&!resolve_taken_in |-> !alloc_out)
    else $error("alloc");
  a_hit_no_alloc: assert property (resolve_valid_in&&resolve_hit_in |-> !alloc_out)
    else $error("hit alloc");
  a_spin_poll: assert property (valid_in&&spin_hint_in |=>
    nop_issue_out ##0 poll_loop_out[*8]) else $error("hint");
  c_hint: cover property (nop_issue_out);
  c_alloc: cover property (alloc_out);
  c_taken: cover property (pred_taken_out);
endmodule
bind sbp_static_branch_predictor sbp_asserts sbp_asserts_inst (.*);

// ===== testbench/sbp_static_branch_predictor_test.sv
`timescale 1ns/1ps
// Predictor bench.
module sbp_static_branch_predictor_test;
  logic core_clk_in = 0, rst_in = 1, resolve_valid_in = 0, resolve_taken_in = 0;
  logic resolve_hit_in = 0;
  wire valid_in, spin_hint_in, btb_hit_in, btb_taken_in, pred_valid_out, pred_taken_out;
  wire alloc_out, nop_issue_out, poll_loop_out;
  wire [1:0] type_in, pred_src_out, resolve_type_in = 2'h3;
  wire [31:0] pc_in, target_in, pred_pc_out, next_pc_in = pc_in+4, btb_target_in = ~target_in;
  int err_total = 0, checked = 0;
  always #25 core_clk_in = ~core_clk_in;
  sbp_fetch_model sbp_fetch_model_inst (.core_clk_in, .f_out({valid_in, spin_hint_in,
    btb_hit_in, btb_taken_in, type_in, pc_in, target_in}));
  sbp_static_branch_predictor sbp_static_branch_predictor_inst (.*);
  task automatic cmp(input logic [35:0] g, e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %h", $time, g);
    end
  endtask
  task automatic stop_test;
    $display("err_total %0d checked %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One branch for a single cycle; its prediction follows one cycle later.
  task automatic br(input logic [69:0] f, input logic [34:0] e);
    sbp_fetch_model_inst.put(f);
    sbp_fetch_model_inst.put('0);
    cmp({pred_valid_out, pred_taken_out, pred_pc_out, pred_src_out}, {1'b1, e});
  endtask
  task automatic t_pred;
    br({6'h21, 32'h100, 32'h80}, {1'b1, 32'h80, 2'h1});
    br({6'h26, 32'h100, 32'h200}, {1'b0, 32'h104, 2'h1});
    br({6'h23, 32'h100, 32'h100}, {1'b0, 32'h104, 2'h1});
    br({6'h23, 32'h100, 32'hFC}, {1'b1, 32'hFC, 2'h1});
    br({6'h2B, 32'h100, 32'hFC}, {1'b0, 32'h104, 2'h2});
    br({6'h2E, 32'h100, 32'h200}, {1'b1, ~32'h200, 2'h2});
  endtask
  task automatic t_spin;
    sbp_fetch_model_inst.put({6'h30, 64'h0});
    sbp_fetch_model_inst.put('0);
    cmp({pred_valid_out, nop_issue_out, poll_loop_out}, 3'h3);
    repeat (15) @(posedge core_clk_in);
    #1 cmp(poll_loop_out, 1'b1);
    @(posedge core_clk_in) #1 cmp(poll_loop_out, 1'b0);
  endtask
  task automatic t_alloc;
    resolve_valid_in = 1;
    #1 cmp(alloc_out, 1'b0);
    resolve_taken_in = 1;
    #1 cmp(alloc_out, 1'b1);
    resolve_hit_in = 1;
    #1 cmp(alloc_out, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge core_clk_in);
    #1 rst_in = 0;
    t_pred;
    t_spin;
    t_alloc;
    stop_test;
  end
  initial begin
    #20000 err_total++;
    stop_test;
  end
endmodule
